// >>> piu_top.sv
// Pin interrupt unit: per-line detect, filter, mask, flag and wake.
// Assumes clk_sys stands in for the synchronising clock; control strobes
// are one-cycle pulses from logic on clk_sys, and pins are asynchronous.
//
// Functional notes
// RULE_01 - Mode bit zero selects edge detection, one selects level detection.
// RULE_02 - Edge lines: polarity zero triggers on falling, one on rising edge.
// RULE_03 - Level lines: level bit zero triggers on low, one on high.
// RULE_04 - Mask-set write opens request path, mask-clear closes it; mask is readable.
// RULE_05 - Trigger sets status flag; stays until flag-clear write or line disabled.
// RULE_06 - Enable write turns detection on, disable write off; enable state readable.
// RULE_07 - Enabled but masked line: no request and no wake, yet flag still sets.
// RULE_08 - Disabled line always holds its status flag at zero.
// RULE_09 - Line-disable write also clears the line's status flag.
// RULE_10 - After reset every line, the non-maskable one included, is disabled.
// RULE_11 - Software should configure trigger and filter before enabling a line.
// RULE_12 - Synchronous mode samples pin with two cycles of latency.
// RULE_13 - Filter asserts trigger on two of last three samples, adding delay.
// RULE_14 - Non-maskable line shares all controls via its own bit position.
// RULE_15 - Non-maskable request drives the CPU's non-maskable input, still enable-gated.
// RULE_16 - Asynchronous lines bypass filter and treat edge setting as level.
// RULE_17 - Asynchronous edge lines: polarity zero means low level, one high.
// RULE_18 - Asynchronous line raises wake at once; flag and request next edge.
// RULE_19 - With clock stopped only asynchronous lines act; wake restarts clock.
// RULE_20 - A line wakes the device only when its mask bit is one.
// RULE_21 - Each line has its own individually maskable request output.
// RULE_22 - Line count is a parameter; bit zero is the non-maskable line.
`timescale 1ns/100ps
module piu_top #(
  parameter int unsigned LINES = piu_pkg::LINES_DFLT
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [LINES-1:0] ext_line_in,
  input  wire logic [LINES-1:0] mode_level,
  input  wire logic [LINES-1:0] edge_rise,
  input  wire logic [LINES-1:0] level_high,
  input  wire logic [LINES-1:0] filter_on,
  input  wire logic [LINES-1:0] select_reg_a,
  input  wire logic [LINES-1:0] mask_set_reg,
  input  wire logic [LINES-1:0] mask_clear_reg,
  input  wire logic [LINES-1:0] flag_clear_reg,
  input  wire logic [LINES-1:0] line_enable_reg,
  input  wire logic [LINES-1:0] line_disable_reg,
  output logic      [LINES-1:0] mask_reg,
  output logic      [LINES-1:0] status_flag_reg,
  output logic      [LINES-1:0] ctrl_reg,
  output logic      [LINES-1:0] line_irq,
  output logic                  nmi_req,
  output logic                  wake_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Parameter check, refused at elaboration
  generate
    if (LINES < 2 || LINES > 31)
    begin : g_bad_lines
      $error("LINES must be 2 to 31");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [LINES-1:0] pin_s;
  logic [LINES-1:0] pin_prev_q;
  logic [LINES-1:0] cond_raw;
  logic [LINES-1:0] cond_vote;
  logic [LINES-1:0] trig_sync;
  logic [LINES-1:0] trig_select_reg_a;
  logic [LINES-1:0] trig_any;
  logic [LINES-1:0] mask_q;
  logic [LINES-1:0] mask_d;
  logic [LINES-1:0] en_q;
  logic [LINES-1:0] en_d;
  logic [LINES-1:0] flag_q;
  logic [LINES-1:0] flag_d;
  logic [LINES-1:0] wake_vec;

  // Level test shared by synchronous and asynchronous paths
  function automatic logic lvl_hit(input logic pin, input logic high);
    lvl_hit = high ? pin : ~pin;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  piu_sync #(
    .W (LINES)
  ) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .select_reg_a_in (ext_line_in),
    .sync_out (pin_s)
  );                                                           // RULE_12

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pin_prev_q <= '0;
    else
      pin_prev_q <= pin_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line trigger condition
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : g_line
      wire edge_hit = edge_rise[g] ? (pin_s[g] & ~pin_prev_q[g])
                                   : (~pin_s[g] & pin_prev_q[g]); // RULE_02
      wire lvl_s    = lvl_hit(pin_s[g], level_high[g]);            // RULE_03
      assign cond_raw[g]   = mode_level[g] ? lvl_s : edge_hit;     // RULE_01
      // Select_reg_a: edge setting read as a level polarity
      assign trig_select_reg_a[g] = en_q[g] & select_reg_a[g] &
                             (mode_level[g] ? lvl_hit(ext_line_in[g], level_high[g])
                                            : lvl_hit(ext_line_in[g], edge_rise[g])); // RULE_16 RULE_17
      assign trig_sync[g]  = en_q[g] & ~select_reg_a[g] &
                             (filter_on[g] ? cond_vote[g] : cond_raw[g]); // RULE_13 RULE_16
    end
  endgenerate

  piu_vote #(
    .W (LINES)
  ) u_vote (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .cond_in  (cond_raw),
    .vote_out (cond_vote)
  );                                                           // RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Mask, enable and status
  assign trig_any = trig_sync | trig_select_reg_a;
  assign mask_d   = (mask_q | mask_set_reg) & ~mask_clear_reg;     // RULE_04
  assign en_d     = (en_q | line_enable_reg) & ~line_disable_reg;  // RULE_06
  // Set beats clear, but disable always empties the flag
  assign flag_d   = ((flag_q & ~flag_clear_reg) | trig_any) & en_d; // RULE_05 RULE_08 RULE_09

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mask_q <= {LINES{piu_pkg::MASK_RST}};
      en_q   <= {LINES{piu_pkg::CTRL_RST}};                    // RULE_10
      flag_q <= {LINES{piu_pkg::FLAG_RST}};
    end
    else
    begin
      mask_q <= mask_d;
      en_q   <= en_d;
      flag_q <= flag_d;                                        // RULE_18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign mask_reg        = mask_q;
  assign ctrl_reg        = en_q;
  assign status_flag_reg = flag_q;
  // Masked flag still sets but never requests
  assign line_irq        = flag_q & mask_q;                     // RULE_07 RULE_21 RULE_22
  assign nmi_req         = line_irq[piu_pkg::NMI_POS];          // RULE_14 RULE_15
  // Select_reg_a term is combinational so wake works without a clock
  assign wake_vec        = (flag_q | trig_select_reg_a) & mask_q;      // RULE_19 RULE_20
  assign wake_out        = |wake_vec;                           // RULE_18

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  flag_needs_en_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(flag_q & ~en_q) == 1'b0)                                  // RULE_08
    else $error("flag set on disabled line");
  disable_clears_a: assert property (@(posedge clk_sys) disable iff (srst)
    |line_disable_reg |=> (flag_q & $past(line_disable_reg)) == '0) // RULE_09
    else $error("disable did not clear flag");
  mask_gates_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
    (line_irq & ~mask_q) == '0)                                 // RULE_07
    else $error("masked line requested");
  nmi_follows_a: assert property (@(posedge clk_sys) disable iff (srst)
    nmi_req == (flag_q[0] & mask_q[0]))                         // RULE_15
    else $error("nmi request mismatch");
  mask_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(mask_set_reg & ~mask_clear_reg) |=> (mask_q & $past(mask_set_reg & ~mask_clear_reg)) != '0) // RULE_04
    else $error("mask set lost");
  en_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(line_enable_reg & ~line_disable_reg) |=> |en_q)           // RULE_06
    else $error("enable lost");
  trig_sets_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(trig_any & en_d) |=> |flag_q)                             // RULE_05
    else $error("trigger did not set flag");
  reset_off_a: assert property (@(posedge clk_sys)
    srst |=> (en_q == '0 && flag_q == '0))                      // RULE_10
    else $error("line enabled after reset");
  wake_masked_a: assert property (@(posedge clk_sys) disable iff (srst)
    wake_out |-> |mask_q)                                       // RULE_20
    else $error("wake without mask");
  select_reg_a_wake_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(trig_select_reg_a & mask_q) |-> wake_out)                        // RULE_18
    else $error("select_reg_a trigger gave no wake");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    |(flag_clear_reg & ~trig_any) |=> (flag_q & $past(flag_clear_reg & ~trig_any)) == '0) // RULE_05
    else $error("flag clear lost");
  mask_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    |mask_clear_reg |=> (mask_q & $past(mask_clear_reg)) == '0) // RULE_04
    else $error("mask clear lost");
  en_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    |line_disable_reg |=> (en_q & $past(line_disable_reg)) == '0) // RULE_06
    else $error("disable lost");
  irq_follows_a: assert property (@(posedge clk_sys) disable iff (srst)
    line_irq == (flag_q & mask_q))                              // RULE_21
    else $error("line request mismatch");
endmodule

// >>> piu_pkg.sv
// Package for the pin interrupt unit: reset values and timing counts.
// Assumes one system clock; per-line controls arrive as plain ports.
package piu_pkg;
  localparam int unsigned LINES_DFLT   = 8;
  localparam int unsigned NMI_POS      = 0;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned VOTE_TAPS    = 3;
  localparam int unsigned VOTE_NEED    = 2;
  localparam bit          CTRL_RST     = 1'b0;
  localparam bit          MASK_RST     = 1'b0;
  localparam bit          FLAG_RST     = 1'b0;
  typedef enum logic [1:0] {PIU_EDGE_FALL, PIU_EDGE_RISE, PIU_LVL_LOW, PIU_LVL_HIGH} piu_trig_t;
endpackage

// >>> piu_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/100ps
module piu_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] select_reg_a_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= select_reg_a_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> piu_vote.sv
// Three-sample majority voter, one per line.
// Assumes a synchronous condition input on clk_sys.
`timescale 1ns/100ps
module piu_vote #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] cond_in,
  output logic      [W-1:0] vote_out
);
  logic [W-1:0] tap1_q;
  logic [W-1:0] tap2_q;
  logic [W-1:0] vote_q;
  logic [W-1:0] vote_d;

  // Two of the latest three samples
  assign vote_d = (cond_in & tap1_q) | (cond_in & tap2_q) | (tap1_q & tap2_q);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tap1_q <= '0;
      tap2_q <= '0;
      vote_q <= '0;
    end
    else
    begin
      tap1_q <= cond_in;
      tap2_q <= tap1_q;
      vote_q <= vote_d;
    end
  end

  assign vote_out = vote_q;
endmodule

// >>> piu_far.sv
// Far side model: drives the pins and collects requests seen by the CPU side.
// Assumes the bench sets pin levels away from the rising edge of clk_sys.
`timescale 1ns/100ps
module piu_far #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_set,
  input  wire logic [W-1:0] line_irq,
  output logic      [W-1:0] ext_line_in,
  output logic      [W-1:0] irq_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // Pins are plain levels; no pull, the bench always drives them
  assign ext_line_in = pin_set;
  // Sticky per-line record, so a short request is not missed
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      irq_seen <= '0;
    else
      irq_seen <= irq_seen | line_irq;
  end
endmodule

// >>> tb.sv
// Self-checking bench for the pin interrupt unit, four lines.
// Assumes piu_top and piu_far; inputs change at the falling edge.
`timescale 1ns/100ps
module tb;
  localparam int unsigned N = 4;
  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic [N-1:0] pins = '0, mode_level = '0, edge_rise = '0, level_high = '0, filter_on = '0;
  logic [N-1:0] select_reg_a = '0, mask_set_reg = '0, mask_clear_reg = '0, flag_clear_reg = '0;
  logic [N-1:0] line_enable_reg = '0, line_disable_reg = '0;
  logic [N-1:0] ext_line_in, mask_reg, status_flag_reg, ctrl_reg, line_irq, irq_seen;
  logic         nmi_req, wake_out;
  int           n_fail = 0;
  int           n_tests = 0;
  always #50 clk_sys = ~clk_sys;
  piu_top #(.LINES(N)) piu_top_i (.clk_sys, .srst, .ext_line_in, .mode_level, .edge_rise, .level_high,
    .filter_on, .select_reg_a, .mask_set_reg, .mask_clear_reg, .flag_clear_reg, .line_enable_reg,
    .line_disable_reg, .mask_reg, .status_flag_reg, .ctrl_reg, .line_irq, .nmi_req, .wake_out);
  piu_far #(.W(N)) piu_far_i (.clk_sys, .srst, .pin_set(pins), .line_irq, .ext_line_in, .irq_seen);
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [N-1:0] seen, input logic [N-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Pulses last one cycle; held low a cycle after so no two land together
  task automatic pulse(input int sel, input logic [N-1:0] v);
    @(negedge clk_sys);
    case (sel)
      0: mask_set_reg = v;
      1: mask_clear_reg = v;
      2: flag_clear_reg = v;
      3: line_enable_reg = v;
      default: line_disable_reg = v;
    endcase
    @(negedge clk_sys);
    {mask_set_reg, mask_clear_reg, flag_clear_reg, line_enable_reg, line_disable_reg} = '0;
  endtask
  // Cfg is {select_reg_a, filter, level_high, edge_rise, mode_level}; w ends the pin pulse early
  task automatic run(input int b, input logic [4:0] cfg, input logic pre, input int w, lo, hi);
    int           k;
    logic [N-1:0] m;
    m = N'(1) << b;
    pins[b] = pre;
    {select_reg_a[b], filter_on[b], level_high[b], edge_rise[b], mode_level[b]} = cfg;
    cyc(2);
    pulse(3, m);
    pulse(0, m);
    cyc(2);
    pins[b] = ~pre;
    if (cfg[4])
    begin
      #1;
      chk("wake select_reg_a", N'(wake_out), N'(1));
    end
    k = 0;
    while (status_flag_reg[b] !== 1'b1 && k < 8)
    begin
      cyc(1);
      k++;
      if (k == w)
        pins[b] = pre;
    end
    chk("latency", N'(k >= lo && k <= hi), N'(1));
    if (hi < 8)
    begin
      chk("irq", line_irq, m);
      chk("nmi", N'(nmi_req), N'(b == 0));
      chk("wake", N'(wake_out), N'(1));
    end
    pulse(4, m);
    pulse(1, m);
    chk("flag off", status_flag_reg, '0);
    chk("wake off", N'(wake_out), '0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(2);
    srst = 1'b0;
    chk("ctrl rst", ctrl_reg, '0);
    chk("flag rst", status_flag_reg | mask_reg | line_irq, '0);
    run(1, 5'h05, 1'b0, 99, 3, 3);
    run(1, 5'h01, 1'b1, 99, 3, 3);
    run(1, 5'h05, 1'b0, 1, 3, 3);
    run(2, 5'h02, 1'b0, 99, 3, 3);
    run(2, 5'h00, 1'b1, 99, 3, 3);
    run(2, 5'h02, 1'b1, 99, 8, 8);
    run(0, 5'h05, 1'b0, 99, 3, 3);
    run(3, 5'h0D, 1'b0, 99, 4, 5);
    run(3, 5'h0D, 1'b0, 1, 8, 8);
    run(3, 5'h12, 1'b0, 99, 1, 1);
    run(3, 5'h10, 1'b1, 99, 1, 1);
    run(3, 5'h1A, 1'b0, 1, 1, 1);
    pins[1] = 1'b1;
    cyc(2);
    pulse(3, 4'h2);
    cyc(3);
    chk("ctrl", ctrl_reg, 4'h2);
    chk("flag masked", status_flag_reg, 4'h2);
    chk("irq masked", line_irq, '0);
    pulse(2, 4'h2);
    chk("clear vs trigger", status_flag_reg, 4'h2);
    pins[1] = 1'b0;
    cyc(3);
    pulse(2, 4'h2);
    chk("clear", status_flag_reg, '0);
    pulse(0, 4'h2);
    chk("mask set", mask_reg, 4'h2);
    pulse(1, 4'h2);
    chk("mask clr", mask_reg, '0);
    pulse(4, 4'h2);
    pins[1] = 1'b1;
    cyc(4);
    chk("ctrl off", ctrl_reg, '0);
    chk("flag disabled", status_flag_reg, '0);
    chk("seen", irq_seen, 4'hF);
    summarize();
  end
endmodule
